// ### rtl/i2csi_regs.vh
// register indices, field positions and reset values of the serial bus status block
`ifndef I2CSI_REGS_VH
`define I2CSI_REGS_VH

// register indices; byte address is four times the index
`define I2CSI_IDX_DATA_BUFFER 4'h0
`define I2CSI_IDX_STATUS 4'h1
`define I2CSI_IDX_IRQ_ENABLE 4'h2
`define I2CSI_IDX_CONTROL 4'h3

// status register fields
`define I2CSI_ST_START 0
`define I2CSI_ST_TX_COMPLETE 1
`define I2CSI_ST_RX_READY 2
`define I2CSI_ST_CLOCK_STRETCH 3
`define I2CSI_ST_TIMEOUT 4
`define I2CSI_ST_ADDR_MATCH 5
`define I2CSI_ST_ARB_LOST 6
`define I2CSI_ST_NOT_ACKED 7
`define I2CSI_ST_GENERAL_CALL 8
`define I2CSI_ST_RX_OVERRUN 9
`define I2CSI_ST_CLOCK_LINE 10
`define I2CSI_ST_STOP 11
`define I2CSI_ST_CTRL_ACTIVE 14
`define I2CSI_ST_BUS_OCCUPIED 15

// sticky event flags, and those software may also set to 1
`define I2CSI_EVENT_MASK 16'h0bff
`define I2CSI_SW_SET_MASK 16'h0b33

// control register fields
`define I2CSI_CTL_MODULE_ENABLE 0
`define I2CSI_CTL_GC_RECOGNITION 1

// writable bits and reset values
`define I2CSI_IRQ_ENABLE_MASK 16'h0bff
`define I2CSI_IRQ_ENABLE_RESET 16'h0000
`define I2CSI_STATUS_RESET 16'h0000
`define I2CSI_CONTROL_MASK 16'h0003
`define I2CSI_CONTROL_RESET 16'h0000
`define I2CSI_DATA_BUFFER_MASK 16'h03ff
`define I2CSI_DATA_BUFFER_RESET 16'h0000

`endif

// ### rtl/i2csi_sync.v
// two flip-flop synchroniser for levels arriving from pins
`timescale 1ns/100ps
`default_nettype none

module i2csi_sync
#(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
)
(
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

reg [WIDTH-1:0] meta_q;
reg [WIDTH-1:0] sync_q;

// the first stage feeds only the second; nothing else looks at it
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        meta_q <= INIT;
        sync_q <= INIT;
    end
    else
    begin
        meta_q <= async_i;
        sync_q <= meta_q;
    end
end

assign sync_o = sync_q;

endmodule

`default_nettype wire

// ### rtl/i2csi_status_irq.v
// status flags, interrupt enable and data buffer gate of the two-wire bus controller
`timescale 1ns/100ps
`default_nettype none
`include "i2csi_regs.vh"

module i2csi_status_irq
#(
    parameter ADDR_WIDTH = 4,
    parameter BUF_WIDTH = 10
)
(
    input wire clk_i,
    input wire rst_i,
    // classic wishbone slave, word addressed
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [ADDR_WIDTH-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // clock line pin, asynchronous
    input wire scl_i,
    // one-cycle event pulses, received data and the controller active level from the shifting engine
    input wire start_seen_i,
    input wire stop_seen_i,
    input wire tx_complete_i,
    input wire clock_stretch_i,
    input wire timeout_i,
    input wire own_address_match_i,
    input wire arbitration_lost_i,
    input wire not_acked_i,
    input wire general_call_i,
    input wire rx_byte_i,
    input wire [BUF_WIDTH-1:0] rx_data_i,
    input wire controller_active_i,
    // towards the shifting engine and the cpu
    output wire [BUF_WIDTH-1:0] tx_data_o,
    output wire tx_load_o,
    output wire module_enable_o,
    output wire general_call_recognition_en_o,
    output wire irq_o
);

////////////////////////////////////////////////////////////////////////////////
// helpers

// merge a bus write into a 16-bit register under byte enables
function [15:0] lane_merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0] sel;
    begin
        lane_merge[7:0] = sel[0] ? new_val[7:0] : old_val[7:0];
        lane_merge[15:8] = sel[1] ? new_val[15:8] : old_val[15:8];
    end
endfunction

// decode a register index against the current address
function idx_hit;
    input [ADDR_WIDTH-1:0] adr;
    input [3:0] idx;
    begin
        idx_hit = (adr == idx[ADDR_WIDTH-1:0]);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// declarations

reg ack_q;
reg [31:0] dat_q;
reg [15:0] flags_q;
reg [15:0] flags_d;
reg ovr_pend_q;
reg ovr_pend_d;
reg rx_unread_q;
reg rx_unread_d;
reg [BUF_WIDTH-1:0] rx_buf_q;
reg [BUF_WIDTH-1:0] tx_buf_q;
reg tx_load_q;
reg [15:0] irq_en_q;
reg [15:0] ctl_q;
reg busy_q;
reg bus_occ_q;
reg bus_occ_d;
reg irq_q;
reg [15:0] status_rd;
reg [31:0] rd_mux;
reg [15:0] hw_set;
reg [15:0] sw_wr_val;
reg [15:0] irq_src;

wire scl_s;
wire access;
wire wr_acc;
wire rd_acc;
wire st_wr;
wire buf_rd;
wire buf_wr;
wire [15:0] wr_word;
wire gc_en;
wire mod_en;
wire [15:0] tx_merge;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisation

i2csi_sync
#(
    .WIDTH(1),
    .INIT(1'b1)
)
u_scl_sync
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(scl_i),
    .sync_o(scl_s)
);

////////////////////////////////////////////////////////////////////////////////
// bus slave: one access per request, answered one cycle after it is seen

assign access = wb_cyc_i & wb_stb_i & ~ack_q;
assign wr_acc = access & wb_we_i;
assign rd_acc = access & ~wb_we_i;
assign wr_word = wb_dat_i[15:0];
assign st_wr = wr_acc & idx_hit(wb_adr_i, `I2CSI_IDX_STATUS);
assign buf_rd = rd_acc & idx_hit(wb_adr_i, `I2CSI_IDX_DATA_BUFFER);
// transmit buffer is locked while a transfer is in flight
assign buf_wr = wr_acc & idx_hit(wb_adr_i, `I2CSI_IDX_DATA_BUFFER) & ~busy_q;
assign mod_en = ctl_q[`I2CSI_CTL_MODULE_ENABLE];
assign gc_en = ctl_q[`I2CSI_CTL_GC_RECOGNITION];

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ack_q <= 1'b0;
        dat_q <= 32'h00000000;
    end
    else
    begin
        ack_q <= access;
        dat_q <= rd_acc ? rd_mux : 32'h00000000;
    end
end

always @*
begin
    status_rd = flags_q & `I2CSI_EVENT_MASK;
    status_rd[`I2CSI_ST_CLOCK_LINE] = scl_s;
    status_rd[`I2CSI_ST_CTRL_ACTIVE] = busy_q;
    status_rd[`I2CSI_ST_BUS_OCCUPIED] = bus_occ_q;
end

// unmapped indices answer normally with zero data
always @*
begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
        `I2CSI_IDX_DATA_BUFFER:
            rd_mux[BUF_WIDTH-1:0] = rx_buf_q;
        `I2CSI_IDX_STATUS:
            rd_mux[15:0] = status_rd;
        `I2CSI_IDX_IRQ_ENABLE:
            rd_mux[15:0] = irq_en_q;
        `I2CSI_IDX_CONTROL:
            rd_mux[15:0] = ctl_q;
        default:
            rd_mux = 32'h00000000;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// control and interrupt enable registers

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        irq_en_q <= `I2CSI_IRQ_ENABLE_RESET;
        ctl_q <= `I2CSI_CONTROL_RESET;
    end
    else
    begin
        if (wr_acc && idx_hit(wb_adr_i, `I2CSI_IDX_IRQ_ENABLE))
        begin
            irq_en_q <= lane_merge(irq_en_q, wr_word, wb_sel_i[1:0])
                & `I2CSI_IRQ_ENABLE_MASK;
        end
        if (wr_acc && idx_hit(wb_adr_i, `I2CSI_IDX_CONTROL))
        begin
            ctl_q <= lane_merge(ctl_q, wr_word, wb_sel_i[1:0]) & `I2CSI_CONTROL_MASK;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// data buffer: separate receive and transmit holding registers

// merged at full register width, then cut to the buffer's own width
assign tx_merge = lane_merge({{(16-BUF_WIDTH){1'b0}}, tx_buf_q}, wr_word, wb_sel_i[1:0]);

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        rx_buf_q <= {BUF_WIDTH{1'b0}};
        tx_buf_q <= {BUF_WIDTH{1'b0}};
        tx_load_q <= 1'b0;
    end
    else
    begin
        if (rx_byte_i)
        begin
            rx_buf_q <= rx_data_i;
        end
        if (buf_wr)
        begin
            tx_buf_q <= tx_merge[BUF_WIDTH-1:0];
        end
        tx_load_q <= buf_wr;
    end
end

// a received byte stays unread until the cpu reads the buffer
always @*
begin
    rx_unread_d = rx_unread_q;
    if (buf_rd)
    begin
        rx_unread_d = 1'b0;
    end
    // a byte landing in the same cycle as the read is still unread
    if (rx_byte_i)
    begin
        rx_unread_d = 1'b1;
    end
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        rx_unread_q <= 1'b0;
    end
    else
    begin
        rx_unread_q <= rx_unread_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// event flags

always @*
begin
    hw_set = 16'h0000;
    hw_set[`I2CSI_ST_START] = start_seen_i;
    hw_set[`I2CSI_ST_TX_COMPLETE] = tx_complete_i;
    hw_set[`I2CSI_ST_RX_READY] = rx_byte_i;
    hw_set[`I2CSI_ST_CLOCK_STRETCH] = clock_stretch_i;
    hw_set[`I2CSI_ST_TIMEOUT] = timeout_i;
    hw_set[`I2CSI_ST_ADDR_MATCH] = own_address_match_i;
    hw_set[`I2CSI_ST_ARB_LOST] = arbitration_lost_i;
    hw_set[`I2CSI_ST_NOT_ACKED] = not_acked_i;
    // general call only counts while its recognition is on
    hw_set[`I2CSI_ST_GENERAL_CALL] = general_call_i & gc_en;
    // a second byte arriving before the buffer is read
    hw_set[`I2CSI_ST_RX_OVERRUN] = rx_byte_i & rx_unread_q & ~buf_rd;
    hw_set[`I2CSI_ST_STOP] = stop_seen_i;
end

// software may clear any sticky flag, but may set only some of them;
// hardware-only flags ignore a written 1 so a stray write cannot fake an event
always @*
begin
    sw_wr_val = lane_merge(flags_q, wr_word, wb_sel_i[1:0]);
    sw_wr_val = (sw_wr_val & (flags_q | `I2CSI_SW_SET_MASK)) & `I2CSI_EVENT_MASK;
end

always @*
begin
    flags_d = flags_q;
    if (st_wr)
    begin
        flags_d = sw_wr_val;
    end
    if (buf_rd)
    begin
        flags_d[`I2CSI_ST_RX_OVERRUN] = 1'b0;
    end
    // a hardware event beats a clear in the same cycle
    flags_d = flags_d | hw_set;
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        flags_q <= `I2CSI_STATUS_RESET;
    end
    else
    begin
        flags_q <= flags_d;
    end
end

// the overrun interrupt is held apart from its flag: writing 0 to the flag
// leaves the request standing, only a buffer read retires it
always @*
begin
    ovr_pend_d = ovr_pend_q;
    if (buf_rd)
    begin
        ovr_pend_d = 1'b0;
    end
    if (hw_set[`I2CSI_ST_RX_OVERRUN])
    begin
        ovr_pend_d = 1'b1;
    end
    if (st_wr && sw_wr_val[`I2CSI_ST_RX_OVERRUN] && !flags_q[`I2CSI_ST_RX_OVERRUN])
    begin
        ovr_pend_d = 1'b1;
    end
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ovr_pend_q <= 1'b0;
    end
    else
    begin
        ovr_pend_q <= ovr_pend_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// hardware driven status

always @*
begin
    bus_occ_d = bus_occ_q;
    if (stop_seen_i)
    begin
        bus_occ_d = 1'b0;
    end
    if (start_seen_i)
    begin
        bus_occ_d = 1'b1;
    end
    if (!mod_en)
    begin
        bus_occ_d = 1'b0;
    end
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        bus_occ_q <= 1'b0;
        busy_q <= 1'b0;
    end
    else
    begin
        bus_occ_q <= bus_occ_d;
        busy_q <= controller_active_i;
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt request

always @*
begin
    irq_src = flags_q & `I2CSI_EVENT_MASK;
    irq_src[`I2CSI_ST_RX_OVERRUN] = ovr_pend_q;
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        irq_q <= 1'b0;
    end
    else
    begin
        // one enable per flag position, bits 0..9 and 11
        irq_q <= |(irq_src & irq_en_q);
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign wb_ack_o = ack_q;
assign wb_dat_o = dat_q;
assign tx_data_o = tx_buf_q;
assign tx_load_o = tx_load_q;
assign module_enable_o = ctl_q[`I2CSI_CTL_MODULE_ENABLE];
assign general_call_recognition_en_o = ctl_q[`I2CSI_CTL_GC_RECOGNITION];
assign irq_o = irq_q;

endmodule

`default_nettype wire

// ### tb/i2csi_status_irq_monitor.sv
// checker on the ports of the serial bus status and interrupt block
`timescale 1ns/100ps
`default_nettype none
module i2csi_status_irq_monitor
#(parameter ADDR_WIDTH = 4)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic scl_i,
    input wire logic controller_active_i,
    input wire logic tx_load_o,
    input wire logic irq_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire rd_st = take && !wb_we_i && wb_adr_i == 1;
wire rd_ie = take && !wb_we_i && wb_adr_i == 2;
wire wr_buf = take && wb_we_i && wb_adr_i == 0;
logic scl_p;
logic ctl_q;
logic [2:0] scl_n;
// the count saturates so a long steady line never wraps back to a short one
always @(posedge clk_i)
begin
    scl_p <= scl_i;
    ctl_q <= rst_i ? 1'b0 : controller_active_i;
    scl_n <= (rst_i || scl_i != scl_p) ? 3'h0 : scl_n + {2'h0, scl_n != 3'h7};
end
////////////////////////////////////////
sequence s_busy_wr;
    wr_buf && ctl_q && controller_active_i;
endsequence
sequence s_idle_wr;
    wr_buf && !ctl_q && !controller_active_i;
endsequence
a_ack_next: assert property (take |=> wb_ack_o)
    else $error("request not acknowledged");
a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack wider than one cycle");
a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
a_status_reserved: assert property (rd_st |=> wb_dat_o[31:16] == 16'h0 && !wb_dat_o[13:12])
    else $error("status reserved bits set");
a_enable_reserved: assert property (rd_ie |=> wb_dat_o[31:12] == 20'h0 && !wb_dat_o[10])
    else $error("enable reserved bits set");
a_clock_mirror: assert property (rd_st && scl_n >= 3'h3 |=> wb_dat_o[10] == $past(scl_i, 3))
    else $error("clock line level misread");
a_busy_mirror: assert property (rd_st && ctl_q == controller_active_i |=> wb_dat_o[14] == ctl_q)
    else $error("controller active misread");
a_refuse_write: assert property (s_busy_wr |=> !tx_load_o [*2])
    else $error("buffer loaded while active");
a_accept_write: assert property (s_idle_wr |-> ##[1:2] tx_load_o)
    else $error("buffer write not loaded");
a_irq_release: assert property ($fell(irq_o) && !$past(rst_i) |-> $past(take) || $past(take, 2))
    else $error("interrupt dropped without access");
endmodule
bind i2csi_status_irq i2csi_status_irq_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) i_mon (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .scl_i,
    .controller_active_i, .tx_load_o, .irq_o);
`default_nettype wire

// ### tb/i2csi_bus_model.sv
// far side of the two-wire bus: clock line level and bus conditions
`timescale 1ns/100ps
`default_nettype none
module i2csi_bus_model
(
    input wire logic clk_i,
    output logic scl_o,
    output logic start_o,
    output logic stop_o,
    output logic rx_byte_o,
    output logic [9:0] rx_data_o
);
// clock line rests high on its pull-up between frames
initial
begin
    scl_o = 1'b1;
    start_o = 1'b0;
    stop_o = 1'b0;
    rx_byte_o = 1'b0;
    rx_data_o = 10'h0;
end
task automatic cond(input logic is_stop);
    @(posedge clk_i);
    start_o <= !is_stop;
    stop_o <= is_stop;
    @(posedge clk_i);
    start_o <= 1'b0;
    stop_o <= 1'b0;
endtask
task automatic rx(input logic [9:0] d);
    repeat (8)
    begin
        @(posedge clk_i);
        scl_o <= 1'b0;
        @(posedge clk_i);
        scl_o <= 1'b1;
    end
    rx_byte_o <= 1'b1;
    rx_data_o <= d;
    @(posedge clk_i);
    rx_byte_o <= 1'b0;
    // data is not held after the strobe
    rx_data_o <= ~d;
endtask
// the wait covers the two-stage synchroniser in front of the status bit
task automatic set_scl(input logic v);
    @(posedge clk_i);
    scl_o <= v;
    repeat (4) @(posedge clk_i);
endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the serial bus status and interrupt block
`timescale 1ns/100ps
`default_nettype none
module testbench;
logic clk_i = 1'b0;
logic rst_i = 1'b1;
logic cyc = 1'b0;
logic we = 1'b0;
logic act = 1'b0;
logic [3:0] adr = 4'h0;
logic [3:0] sel = 4'h0;
logic [3:0] lanes = 4'h3;
logic me, gce;
logic [31:0] wdat = 32'h0;
logic [8:0] ev = 9'h0;
logic [31:0] rdat;
logic [9:0] rxd;
logic [9:0] txd;
logic scl, st, sp, rxb, ack, irq, load;
int err_total = 0;
int n_tests = 0;
int loads = 0;
always #50 clk_i = ~clk_i;
always @(posedge clk_i) if (load === 1'b1) loads <= loads + 1;
i2csi_status_irq i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .scl_i(scl), .start_seen_i(st), .stop_seen_i(sp),
    .tx_complete_i(ev[1]), .clock_stretch_i(ev[3]), .timeout_i(ev[4]),
    .own_address_match_i(ev[5]), .arbitration_lost_i(ev[6]), .not_acked_i(ev[7]),
    .general_call_i(ev[8]), .rx_byte_i(rxb), .rx_data_i(rxd), .controller_active_i(act),
    .tx_data_o(txd), .tx_load_o(load), .module_enable_o(me), .general_call_recognition_en_o(gce),
    .irq_o(irq));
i2csi_bus_model i_bus (.clk_i(clk_i), .scl_o(scl), .start_o(st), .stop_o(sp),
    .rx_byte_o(rxb), .rx_data_o(rxd));
////////////////////////////////////////
task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
        begin
        err_total++;
        $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
endtask
task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d, output logic [15:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    wdat <= {16'h0, d};
    // only the watchdog ends a wait for an answer that never comes
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat[15:0];
    cyc <= 1'b0;
endtask
task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] r;
    wb(1'b0, a, 16'h0, r);
    chk(r & m, e);
endtask
task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] r;
    wb(1'b1, a, d, r);
endtask
task automatic irq_is(input logic e);
    repeat (3) @(posedge clk_i);
    chk({15'h0, irq}, {15'h0, e});
endtask
task automatic fire(input int i);
    if (i == 0 || i == 11)
        i_bus.cond(i == 11);
    else if (i == 2)
        i_bus.rx(10'h0a5);
    else
        begin
        @(posedge clk_i);
        ev <= 9'h1 << i;
        @(posedge clk_i);
        ev <= 9'h0;
        end
endtask
////////////////////////////////////////
task automatic t_regs;
    rd(4'h2, 16'hffff, 16'h0000);
    rd(4'h1, 16'hffff, 16'h0400);
    rd(4'h5, 16'hffff, 16'h0000);
    wr(4'h2, 16'hffff);
    rd(4'h2, 16'hffff, 16'h0bff);
    lanes = 4'h2;
    wr(4'h2, 16'h0000);
    lanes = 4'h3;
    rd(4'h2, 16'hffff, 16'h00ff);
    wr(4'h3, 16'h0001);
    chk({14'h0, gce, me}, 16'h0001);
    fire(8);
    rd(4'h1, 16'h0100, 16'h0000);
    wr(4'h3, 16'h0003);
    chk({14'h0, gce, me}, 16'h0003);
    wr(4'h1, 16'hf400);
    rd(4'h1, 16'hffff, 16'h0400);
    wr(4'h2, 16'h0000);
endtask
task automatic t_events;
    int src[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 11};
    foreach (src[k])
        begin
        fire(src[k]);
        irq_is(1'b0);
        rd(4'h1, 16'h1 << src[k], 16'h1 << src[k]);
        wr(4'h2, 16'h1 << src[k]);
        irq_is(1'b1);
        wr(4'h1, 16'h0000);
        irq_is(1'b0);
        wr(4'h2, 16'h0000);
        end
endtask
task automatic t_sw;
    wr(4'h2, 16'h0800);
    wr(4'h1, 16'h0800);
    irq_is(1'b1);
    wr(4'h1, 16'h0000);
    irq_is(1'b0);
    wr(4'h2, 16'h0200);
    wr(4'h1, 16'h0200);
    irq_is(1'b1);
    wr(4'h1, 16'h0000);
    irq_is(1'b1);
    rd(4'h0, 16'hffff, 16'h00a5);
    irq_is(1'b0);
endtask
task automatic t_overrun;
    i_bus.rx(10'h155);
    irq_is(1'b0);
    i_bus.rx(10'h2aa);
    irq_is(1'b1);
    rd(4'h1, 16'h0200, 16'h0200);
    rd(4'h0, 16'hffff, 16'h02aa);
    irq_is(1'b0);
    rd(4'h1, 16'h0200, 16'h0000);
    wr(4'h2, 16'h0000);
endtask
task automatic t_scl;
    i_bus.set_scl(1'b0);
    rd(4'h1, 16'h0400, 16'h0000);
    wr(4'h1, 16'h0400);
    rd(4'h1, 16'h0400, 16'h0000);
    i_bus.set_scl(1'b1);
    rd(4'h1, 16'h0400, 16'h0400);
endtask
task automatic t_busy;
    act <= 1'b1;
    wr(4'h1, 16'h0000);
    rd(4'h1, 16'h4000, 16'h4000);
    wr(4'h0, 16'h03ff);
    repeat (3) @(posedge clk_i);
    chk(16'(loads), 16'h0);
    chk({6'h0, txd}, 16'h0000);
    act <= 1'b0;
    wr(4'h0, 16'h01c3);
    repeat (3) @(posedge clk_i);
    chk(16'(loads), 16'h1);
    chk({6'h0, txd}, 16'h01c3);
    rd(4'h1, 16'h4000, 16'h0000);
endtask
task automatic t_busocc;
    i_bus.cond(1'b0);
    rd(4'h1, 16'h8800, 16'h8000);
    i_bus.cond(1'b1);
    rd(4'h1, 16'h8800, 16'h0800);
    i_bus.cond(1'b0);
    rd(4'h1, 16'h8000, 16'h8000);
    wr(4'h3, 16'h0002);
    chk({14'h0, gce, me}, 16'h0002);
    rd(4'h1, 16'h8000, 16'h0000);
    wr(4'h3, 16'h0003);
    wr(4'h2, 16'h0a00);
    i_bus.cond(1'b0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h1, 16'hffff, 16'h0400);
    rd(4'h2, 16'hffff, 16'h0000);
endtask
initial
begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(4'h3, 16'h0003);
    t_regs();
    t_events();
    t_sw();
    t_overrun();
    t_scl();
    t_busy();
    t_busocc();
    end_of_test();
end
// far beyond the few hundred cycles that the scenarios need
initial
begin
    #2000000;
    err_total++;
    end_of_test();
end
endmodule
`default_nettype wire
